// File: pm_cap_pkg.sv
// Constants for the power-management capability and control/status words
package pm_cap_pkg;

	// ------------------------------------------------------------
	// Word offsets within the capability structure
	// ------------------------------------------------------------
	localparam logic [7:0] CAP_OFS = 8'h02;
	localparam logic [7:0] CSR_OFS = 8'h04;

	// ------------------------------------------------------------
	// Capability word field positions
	// ------------------------------------------------------------
	localparam int WAKE_MASK_LSB = 11;
	localparam int WAKE_MASK_MSB = 15;
	localparam int D2_SUP_BIT = 10;
	localparam int D1_SUP_BIT = 9;
	localparam int AUX_LSB = 6;
	localparam int AUX_MSB = 8;
	localparam int DSI_BIT = 5;
	localparam int CLK_BIT = 3;
	localparam int REV_LSB = 0;
	localparam int REV_MSB = 2;

	// ------------------------------------------------------------
	// Control/status word field positions
	// ------------------------------------------------------------
	localparam int FLAG_BIT = 15;
	localparam int SCALE_LSB = 13;
	localparam int SCALE_MSB = 14;
	localparam int DSEL_LSB = 9;
	localparam int DSEL_MSB = 12;
	localparam int ENABLE_BIT = 8;
	localparam int PSTATE_LSB = 0;
	localparam int PSTATE_MSB = 1;

	// ------------------------------------------------------------
	// Fixed values and reset values
	// ------------------------------------------------------------
	localparam logic [2:0] CAP_REVISION = 3'h2;
	localparam logic [2:0] AUX_NONE = 3'h0;
	localparam logic [1:0] SCALE_NONE = 2'h0;
	localparam logic [3:0] DSEL_RST = 4'h0;
	localparam logic [4:0] WAKE_MASK_RST = 5'h1f;
	localparam logic [2:0] AUX_RST = 3'h2;
	localparam logic [15:0] ZERO_WORD = 16'h0000;

	// Auxiliary current codes, largest draw first
	localparam logic [2:0] AUX_375MA = 3'h7;
	localparam logic [2:0] AUX_320MA = 3'h6;
	localparam logic [2:0] AUX_270MA = 3'h5;
	localparam logic [2:0] AUX_220MA = 3'h4;
	localparam logic [2:0] AUX_160MA = 3'h3;
	localparam logic [2:0] AUX_100MA = 3'h2;
	localparam logic [2:0] AUX_55MA = 3'h1;

	// Power states as held in the two-bit field
	typedef enum logic [1:0]
	{
		PS_D0 = 2'b00,
		PS_D1 = 2'b01,
		PS_D2 = 2'b10,
		PS_D3HOT = 2'b11
	} power_state_t;

endpackage

// File: wake_event_ctrl.sv
// Wake event flag, wake enable and open-drain wake pin drive
`timescale 1ns/1ps
`default_nettype none
module wake_event_ctrl
(
	input wire logic clk,
	input wire logic rst,
	input wire logic wake_req,
	input wire logic state_can_wake,
	input wire logic flag_clr,
	input wire logic enable_wr,
	input wire logic enable_wdata,
	output logic flag_r,
	output logic enable_r,
	output logic wake_pin_oe_n_r
);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	logic flag_nxt;
	logic enable_nxt;
	logic oe_n_nxt;
	logic set_event;

	// Flag sets on a wake request in a wake-capable state, whatever the enable
	always_comb
	begin
		set_event = wake_req & state_can_wake;
		flag_nxt = flag_r;
		if (set_event)
		begin
			flag_nxt = 1'b1;
		end
		else if (flag_clr)
		begin
			flag_nxt = 1'b0;
		end
		enable_nxt = enable_r;
		if (enable_wr)
		begin
			enable_nxt = enable_wdata;
		end
		// Pin pulled low only while flagged and enabled; oe_n low means driving
		oe_n_nxt = ~(flag_nxt & enable_nxt);
	end

	// ------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------
	// No auxiliary-power domain here, so the flag is not sticky across reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			flag_r <= 1'b0;
			enable_r <= 1'b0;
			wake_pin_oe_n_r <= 1'b1;
		end
		else
		begin
			flag_r <= flag_nxt;
			enable_r <= enable_nxt;
			wake_pin_oe_n_r <= oe_n_nxt;
		end
	end

endmodule
`default_nettype wire

// File: pm_cap_regs.sv
// Power-management capability and control/status registers of one function
`timescale 1ns/1ps
`default_nettype none
module pm_cap_regs
#(
	parameter logic [4:0] WAKE_MASK = pm_cap_pkg::WAKE_MASK_RST,
	parameter bit D1_SUPPORT = 1'b1,
	parameter bit D2_SUPPORT = 1'b1,
	parameter logic [2:0] AUX_CURRENT = pm_cap_pkg::AUX_RST,
	parameter bit DEV_INIT_NEEDED = 1'b0,
	parameter bit WAKE_NEEDS_CLK = 1'b0,
	parameter bit DATA_REG_PRESENT = 1'b0
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cfg_sel,
	input wire logic cfg_we,
	input wire logic [7:0] cfg_addr,
	input wire logic [1:0] cfg_be,
	input wire logic [15:0] cfg_wdata,
	input wire logic wake_req,
	output logic [15:0] cfg_rdata_r,
	output logic cfg_ack_r,
	output logic [1:0] power_state_r,
	output logic wake_pin_o_r,
	output logic wake_pin_oe_n_r
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	// The wake bit for a state the function lacks makes no sense
	if ((WAKE_MASK[1] && !D1_SUPPORT) || (WAKE_MASK[2] && !D2_SUPPORT))
	begin : bad_wake_mask
		$error("wake mask names an unsupported low-power state");
	end

	// ------------------------------------------------------------
	// Read-only capability word
	// ------------------------------------------------------------
	logic [15:0] cap_word;
	logic [2:0] aux_field;
	logic clk_field;

	// Aux current yields to the data register and to lack of D3cold wake
	always_comb
	begin
		if (DATA_REG_PRESENT)
		begin
			aux_field = pm_cap_pkg::AUX_NONE;
		end
		else if (!WAKE_MASK[4])
		begin
			aux_field = pm_cap_pkg::AUX_NONE;
		end
		else
		begin
			aux_field = AUX_CURRENT;
		end
	end

	// A function that never wakes cannot depend on the bus clock for it
	assign clk_field = (WAKE_MASK == 5'h00) ? 1'b0 : WAKE_NEEDS_CLK;

	// Assemble the capability word; reserved bit 4 reads zero
	always_comb
	begin
		cap_word = pm_cap_pkg::ZERO_WORD;
		cap_word[pm_cap_pkg::WAKE_MASK_MSB:pm_cap_pkg::WAKE_MASK_LSB] = WAKE_MASK;
		cap_word[pm_cap_pkg::D2_SUP_BIT] = D2_SUPPORT;
		cap_word[pm_cap_pkg::D1_SUP_BIT] = D1_SUPPORT;
		cap_word[pm_cap_pkg::AUX_MSB:pm_cap_pkg::AUX_LSB] = aux_field;
		cap_word[pm_cap_pkg::DSI_BIT] = DEV_INIT_NEEDED;
		cap_word[pm_cap_pkg::CLK_BIT] = clk_field;
		cap_word[pm_cap_pkg::REV_MSB:pm_cap_pkg::REV_LSB] = pm_cap_pkg::CAP_REVISION;
	end

	// ------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------
	logic hit_cap;
	logic hit_csr;
	logic csr_wr;
	logic wr_hi;
	logic wr_lo;

	// Low address bit ignored: both words are 16-bit aligned
	always_comb
	begin
		hit_cap = 1'b0;
		hit_csr = 1'b0;
		if (cfg_addr[7:1] == pm_cap_pkg::CAP_OFS[7:1])
		begin
			hit_cap = 1'b1;
		end
		else if (cfg_addr[7:1] == pm_cap_pkg::CSR_OFS[7:1])
		begin
			hit_csr = 1'b1;
		end
	end

	// Capability hits are acknowledged but never written
	assign csr_wr = cfg_sel & cfg_we & hit_csr;
	assign wr_hi = csr_wr & cfg_be[1];
	assign wr_lo = csr_wr & cfg_be[0];

	logic rd_cap;
	logic rd_csr;

	// Reads qualified once, so the read mux sees one decode only
	assign rd_cap = cfg_sel & ~cfg_we & hit_cap;
	assign rd_csr = cfg_sel & ~cfg_we & hit_csr;

	// ------------------------------------------------------------
	// Power state and data select
	// ------------------------------------------------------------
	logic [1:0] state_nxt;
	logic [3:0] dsel_r;
	logic [3:0] dsel_nxt;
	logic [1:0] req_state;
	logic state_ok;

	// Unsupported optional states are discarded with no status change
	always_comb
	begin
		req_state = cfg_wdata[pm_cap_pkg::PSTATE_MSB:pm_cap_pkg::PSTATE_LSB];
		case (req_state)
			pm_cap_pkg::PS_D1: state_ok = D1_SUPPORT;
			pm_cap_pkg::PS_D2: state_ok = D2_SUPPORT;
			default: state_ok = 1'b1;
		endcase
		state_nxt = power_state_r;
		if (wr_lo && state_ok)
		begin
			state_nxt = req_state;
		end
		dsel_nxt = dsel_r;
		if (wr_hi && DATA_REG_PRESENT)
		begin
			dsel_nxt = cfg_wdata[pm_cap_pkg::DSEL_MSB:pm_cap_pkg::DSEL_LSB];
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			power_state_r <= pm_cap_pkg::PS_D0;
			dsel_r <= pm_cap_pkg::DSEL_RST;
		end
		else
		begin
			power_state_r <= state_nxt;
			dsel_r <= dsel_nxt;
		end
	end

	// ------------------------------------------------------------
	// Wake event logic
	// ------------------------------------------------------------
	logic flag_r;
	logic enable_r;
	logic can_wake;
	logic [3:0] state_hit;
	logic flag_clr;
	logic enable_wdata;

	// D3cold is lost power; one wake bit per live state, matched against the state
	for (genvar i = 0; i < 4; i++)
	begin : live_state
		assign state_hit[i] = (power_state_r == 2'(i)) && WAKE_MASK[i];
	end

	// Only a wake-capable current state may raise the flag
	assign can_wake = |state_hit;

	// High-byte write strobes; a zero in the flag bit leaves the flag alone
	assign flag_clr = wr_hi & cfg_wdata[pm_cap_pkg::FLAG_BIT];
	assign enable_wdata = cfg_wdata[pm_cap_pkg::ENABLE_BIT];

	wake_event_ctrl u_wake
	(
		.clk(clk),
		.rst(rst),
		.wake_req(wake_req),
		.state_can_wake(can_wake),
		.flag_clr(flag_clr),
		.enable_wr(wr_hi),
		.enable_wdata(enable_wdata),
		.flag_r(flag_r),
		.enable_r(enable_r),
		.wake_pin_oe_n_r(wake_pin_oe_n_r)
	);

	// ------------------------------------------------------------
	// Control/status read image and read port
	// ------------------------------------------------------------
	logic [15:0] csr_word;
	logic [15:0] rdata_nxt;
	logic ack_nxt;
	logic pin_o_nxt;

	// Scale reads zero; select reads zero unless a data register exists
	always_comb
	begin
		csr_word = pm_cap_pkg::ZERO_WORD;
		csr_word[pm_cap_pkg::FLAG_BIT] = flag_r;
		csr_word[pm_cap_pkg::SCALE_MSB:pm_cap_pkg::SCALE_LSB] = pm_cap_pkg::SCALE_NONE;
		csr_word[pm_cap_pkg::DSEL_MSB:pm_cap_pkg::DSEL_LSB] = dsel_r;
		csr_word[pm_cap_pkg::ENABLE_BIT] = enable_r;
		csr_word[pm_cap_pkg::PSTATE_MSB:pm_cap_pkg::PSTATE_LSB] = power_state_r;
	end

	// Unmapped offsets read zero; data register (if any) lives elsewhere
	always_comb
	begin
		rdata_nxt = pm_cap_pkg::ZERO_WORD;
		if (rd_cap)
		begin
			rdata_nxt = cap_word;
		end
		else if (rd_csr)
		begin
			rdata_nxt = csr_word;
		end
		// Every access, read or write, mapped or not, acks one cycle later
		ack_nxt = cfg_sel;
		// Open drain: the pin only ever pulls low, so its level never changes
		pin_o_nxt = 1'b0;
	end

	// Read port registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_rdata_r <= pm_cap_pkg::ZERO_WORD;
			cfg_ack_r <= 1'b0;
			wake_pin_o_r <= 1'b0;
		end
		else
		begin
			cfg_rdata_r <= rdata_nxt;
			cfg_ack_r <= ack_nxt;
			wake_pin_o_r <= pin_o_nxt;
		end
	end

endmodule
`default_nettype wire

// File: pm_cap_regs_props.sv
// Checker for the power-management register port
`timescale 1ns/1ps
`default_nettype none
module pm_cap_regs_props
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cfg_sel,
	input wire logic cfg_we,
	input wire logic [7:0] cfg_addr,
	input wire logic [1:0] cfg_be,
	input wire logic [15:0] cfg_wdata,
	input wire logic wake_req,
	input wire logic [15:0] cfg_rdata_r,
	input wire logic cfg_ack_r,
	input wire logic [1:0] power_state_r,
	input wire logic wake_pin_o_r,
	input wire logic wake_pin_oe_n_r
);
	// Decoded accesses; offset bit 0 is ignored
	wire logic rd_any = cfg_sel && !cfg_we;
	wire logic rd_cap = rd_any && cfg_addr[7:1] == 7'h01;
	wire logic rd_csr = rd_any && cfg_addr[7:1] == 7'h02;
	wire logic wr_csr = cfg_sel && cfg_we && cfg_addr[7:1] == 7'h02;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_ack_follows: assert property (cfg_sel |=> cfg_ack_r) else $error("ack missing");
	a_ack_spurious: assert property (!cfg_sel |=> !cfg_ack_r) else $error("stray ack");
	a_cap_wake: assert property (rd_cap |=> cfg_rdata_r[15:11] == 5'h1f) else $error("wake bits");
	a_cap_states: assert property (rd_cap |=> cfg_rdata_r[10:9] == 2'h3) else $error("support");
	a_cap_aux: assert property (rd_cap |=> cfg_rdata_r[8:3] == 6'h10) else $error("aux field");
	a_cap_revision: assert property (rd_cap |=> cfg_rdata_r[2:0] == 3'h2) else $error("rev");
	a_csr_layout: assert property (rd_csr |=> cfg_rdata_r[14:9] == 6'h00
		&& cfg_rdata_r[7:2] == 6'h00) else $error("csr zero fields");
	a_rdata_idle: assert property (!rd_any |=> cfg_rdata_r == 16'h0000) else $error("rdata");
	a_state_write: assert property (wr_csr && cfg_be[0] |=>
		power_state_r == $past(cfg_wdata[1:0])) else $error("state write");
	a_state_hold: assert property (!(wr_csr && cfg_be[0]) |=> $stable(power_state_r))
		else $error("state moved");
	a_flag_clear: assert property (wr_csr && cfg_be[1] && cfg_wdata[15] && !wake_req
		|=> wake_pin_oe_n_r) else $error("pin kept");
	a_set_wins: assert property (wr_csr && cfg_be[1] && cfg_wdata[8] && wake_req
		|=> !wake_pin_oe_n_r) else $error("set lost to clear");
	a_pin_low: assert property (!wake_pin_oe_n_r |-> !wake_pin_o_r) else $error("pin level");

	// Main scenarios reached
	c_cap_read: cover property (rd_cap);
	c_wake_drive: cover property (!wake_pin_oe_n_r);
	c_flag_clear: cover property (wr_csr && cfg_wdata[15]);
	c_set_clear: cover property (wr_csr && cfg_wdata[15] && wake_req);
endmodule
bind pm_cap_regs pm_cap_regs_props i_pm_cap_regs_props (.clk(clk), .rst(rst),
	.cfg_sel(cfg_sel), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
	.cfg_wdata(cfg_wdata), .wake_req(wake_req), .cfg_rdata_r(cfg_rdata_r),
	.cfg_ack_r(cfg_ack_r), .power_state_r(power_state_r), .wake_pin_o_r(wake_pin_o_r),
	.wake_pin_oe_n_r(wake_pin_oe_n_r));
`default_nettype wire

// File: wake_line_pullup.sv
// System side of the open-drain wake line
`timescale 1ns/1ps
`default_nettype none
module wake_line_pullup
(
	input wire logic pin_o,
	input wire logic pin_oe_n,
	output logic line
);
	// Released pin floats to the pull-up, never the last value
	assign line = pin_oe_n ? 1'b1 : pin_o;
endmodule
`default_nettype wire

// File: pm_cap_regs_tb.sv
// Self-checking bench for the power-management registers
`timescale 1ns/1ps
`default_nettype none
module pm_cap_regs_tb;
	logic clk, rst, cfg_sel, cfg_we, wake_req;
	logic [7:0] cfg_addr;
	logic [1:0] cfg_be;
	logic [15:0] cfg_wdata;
	wire logic [15:0] cfg_rdata_r;
	wire logic [1:0] power_state_r;
	wire logic cfg_ack_r, wake_pin_o_r, wake_pin_oe_n_r, wake_line;
	int fails, checks_done, cycles;

	pm_cap_regs i_pm_cap_regs (.clk(clk), .rst(rst), .cfg_sel(cfg_sel), .cfg_we(cfg_we),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .wake_req(wake_req),
		.cfg_rdata_r(cfg_rdata_r), .cfg_ack_r(cfg_ack_r), .power_state_r(power_state_r),
		.wake_pin_o_r(wake_pin_o_r), .wake_pin_oe_n_r(wake_pin_oe_n_r));
	wake_line_pullup i_wake_line_pullup (.pin_o(wake_pin_o_r), .pin_oe_n(wake_pin_oe_n_r),
		.line(wake_line));

	// ------------------------------------------------------------
	// Clock, hang guard and checking tasks
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Whole run is about 70 cycles, so this only trips on a hang
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			fails++;
			$display("MISMATCH %0t timeout", $time);
			tally_and_finish();
		end
	end

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string what);
		chk_word({15'h0000, got}, {15'h0000, exp}, what);
	endtask

	// One access; ack and read data stand only in the cycle after the request
	task automatic cfg_access(input logic we, input logic [7:0] addr, input logic [1:0] be,
		input logic [15:0] wdata, input logic [15:0] exp);
		@(posedge clk);
		#1;
		cfg_sel = 1'b1;
		cfg_we = we;
		cfg_addr = addr;
		cfg_be = be;
		cfg_wdata = wdata;
		@(posedge clk);
		#1;
		cfg_sel = 1'b0;
		chk_bit(cfg_ack_r, 1'b1, "ack");
		if (!we)
			chk_word(cfg_rdata_r, exp, "read");
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial
	begin
		logic [1:0] st;
		{rst, cfg_sel, cfg_we, wake_req} = 4'h8;
		cfg_addr = 8'h00;
		cfg_be = 2'h0;
		cfg_wdata = 16'h0000;
		fails = 0;
		checks_done = 0;
		cycles = 0;
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		chk_bit(wake_line, 1'b1, "idle line");
		cfg_access(1'b0, 8'h04, 2'h3, 16'h0000, 16'h0000);
		cfg_access(1'b0, 8'h02, 2'h3, 16'h0000, 16'hfe82);
		cfg_access(1'b1, 8'h02, 2'h3, 16'h0000, 16'h0000);
		cfg_access(1'b0, 8'h02, 2'h3, 16'h0000, 16'hfe82);
		cfg_access(1'b0, 8'h10, 2'h3, 16'h0000, 16'h0000);
		$display("test capability word done");
		// Walk every state code, ending back in D0
		for (int s = 3; s >= 0; s--)
		begin
			st = s[1:0];
			cfg_access(1'b1, 8'h04, 2'h1, {14'h0000, st}, 16'h0000);
			chk_word({14'h0000, power_state_r}, {14'h0000, st}, "state");
			cfg_access(1'b0, 8'h04, 2'h3, 16'h0000, {14'h0000, st});
		end
		$display("test power states done");
		cfg_access(1'b1, 8'h04, 2'h2, 16'h0100, 16'h0000);
		@(posedge clk);
		#1;
		wake_req = 1'b1;
		@(posedge clk);
		#1;
		wake_req = 1'b0;
		chk_bit(wake_line, 1'b0, "wake drive");
		cfg_access(1'b0, 8'h04, 2'h3, 16'h0000, 16'h8100);
		cfg_access(1'b1, 8'h04, 2'h2, 16'h0000, 16'h0000);
		chk_bit(wake_line, 1'b1, "suppressed");
		cfg_access(1'b0, 8'h04, 2'h3, 16'h0000, 16'h8000);
		cfg_access(1'b1, 8'h04, 2'h2, 16'h8000, 16'h0000);
		cfg_access(1'b0, 8'h04, 2'h3, 16'h0000, 16'h0000);
		$display("test wake event done");
		// Wake request held across a clearing write: the set must win
		wake_req = 1'b1;
		cfg_access(1'b1, 8'h04, 2'h2, 16'h8100, 16'h0000);
		wake_req = 1'b0;
		cfg_access(1'b0, 8'h04, 2'h3, 16'h0000, 16'h8100);
		chk_bit(wake_line, 1'b0, "set wins");
		cfg_access(1'b1, 8'h04, 2'h2, 16'h8000, 16'h0000);
		chk_bit(wake_line, 1'b1, "cleared");
		// Reset mid-run with wake enabled and a low-power state held
		cfg_access(1'b1, 8'h04, 2'h3, 16'h0103, 16'h0000);
		chk_word({14'h0000, power_state_r}, 16'h0003, "state d3hot");
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		chk_word({14'h0000, power_state_r}, 16'h0000, "reset state");
		chk_bit(wake_line, 1'b1, "reset line");
		cfg_access(1'b0, 8'h04, 2'h3, 16'h0000, 16'h0000);
		$display("test priority and reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
